// [dv/pcsb_pin_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// External circuit on one port's pins
// ----------------------------------------------------------------
module pcsb_pin_model #(
  parameter int W = 8                     // Port width
) (
  input  wire logic         CLK,          // Core clock
  input  wire logic [W-1:0] OUT,          // Device output levels
  input  wire logic [W-1:0] OE,           // Device drive enables
  input  wire logic [W-1:0] EXT,          // External drive levels
  input  wire logic [W-1:0] EXT_EN,       // External drive enables
  input  wire logic [W-1:0] PULL_DIS,     // Pull-up disconnect bits
  output logic      [W-1:0] PIN           // Resolved pin levels
);
  logic [W-1:0] last_r;

  // Remember last level so a floating pin can be made to wander
  always_ff @(posedge CLK) begin
    last_r <= PIN;
  end

  // Device drive wins, then external drive, then pull-up, else a toggling level
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (OE[i]) PIN[i] = OUT[i];
      else if (EXT_EN[i]) PIN[i] = EXT[i];
      else if (!PULL_DIS[i]) PIN[i] = 1'b1;
      else PIN[i] = (last_r[i] !== 1'b1);  // Floating: wanders, never unknown
    end
  end
endmodule : pcsb_pin_model
`default_nettype wire

// [dv/test_port_config_select_bank.sv]
`timescale 1ns/10ps
`default_nettype none
module test_port_config_select_bank;
  import pcsb_pkg::*;
  logic         clk, rst_b, sel_wr, cfg_wr, file_wr, file_rd, cmp_result;
  logic         cfg_swap_vld, file_rvld, file_hit, cmp_enable, cmp_route, vld, hit;
  logic [7:0]   sel_wdata, sel_rdata, cfg_swap_data, file_wdata, file_rdata, rd;
  logic [7:0]   pb_in, pb_out, pb_oe, pc_in, pc_out, pc_oe, ext_b, en_b, ext_c, en_c;
  logic [7:0]   wake_mask, wake_edge, wake_pend;
  logic [3:0]   pa_in, pa_out, pa_oe, ext_a, en_a;
  logic [4:0]   file_addr;
  logic         ce;
  logic [7:0]   n_rdata, n_pc_oe;
  pcsb_cfgwr_s  cfg_req;
  pcsb_pincfg_s cfg_a, cfg_b, cfg_c;
  int           err_count, total_checks;

  pcsb_port_config dut_u (.CLK(clk), .RST_B(rst_b), .CE(ce), .SEL_WR(sel_wr), .SEL_WDATA(sel_wdata),
    .SEL_RDATA(sel_rdata), .CFG_WR(cfg_wr), .CFG_REQ(cfg_req), .CFG_SWAP_VLD(cfg_swap_vld),
    .CFG_SWAP_DATA(cfg_swap_data), .FILE_WR(file_wr), .FILE_RD(file_rd), .FILE_ADDR(file_addr),
    .FILE_WDATA(file_wdata), .FILE_RVLD(file_rvld), .FILE_RDATA(file_rdata), .FILE_HIT(file_hit),
    .PA_IN(pa_in), .PA_OUT(pa_out), .PA_OE(pa_oe), .PB_IN(pb_in), .PB_OUT(pb_out), .PB_OE(pb_oe),
    .PC_IN(pc_in), .PC_OUT(pc_out), .PC_OE(pc_oe), .CFG_A(cfg_a), .CFG_B(cfg_b), .CFG_C(cfg_c),
    .WAKE_MASK(wake_mask), .WAKE_EDGE(wake_edge), .WAKE_PEND(wake_pend), .CMP_RESULT(cmp_result),
    .CMP_ENABLE(cmp_enable), .CMP_ROUTE(cmp_route));
  // Reduced variant: 07h is plain storage and port C is never driven
  pcsb_port_config #(.HAS_PORT_C(1'b0)) dut_n (.CLK(clk), .RST_B(rst_b), .CE(ce), .SEL_WR(sel_wr),
    .SEL_WDATA(sel_wdata), .SEL_RDATA(), .CFG_WR(cfg_wr), .CFG_REQ(cfg_req), .CFG_SWAP_VLD(), .CFG_SWAP_DATA(),
    .FILE_WR(file_wr), .FILE_RD(file_rd), .FILE_ADDR(file_addr), .FILE_WDATA(file_wdata), .FILE_RVLD(),
    .FILE_RDATA(n_rdata), .FILE_HIT(), .PA_IN(pa_in), .PA_OUT(), .PA_OE(), .PB_IN(pb_in), .PB_OUT(),
    .PB_OE(), .PC_IN(8'h00), .PC_OUT(), .PC_OE(n_pc_oe), .CFG_A(), .CFG_B(), .CFG_C(), .WAKE_MASK(),
    .WAKE_EDGE(), .WAKE_PEND(), .CMP_RESULT(cmp_result), .CMP_ENABLE(), .CMP_ROUTE());
  pcsb_pin_model #(.W(4)) pin_a (.CLK(clk), .OUT(pa_out), .OE(pa_oe), .EXT(ext_a), .EXT_EN(en_a),
    .PULL_DIS(cfg_a.pullup_dis[3:0]), .PIN(pa_in));
  pcsb_pin_model #(.W(8)) pin_b (.CLK(clk), .OUT(pb_out), .OE(pb_oe), .EXT(ext_b), .EXT_EN(en_b),
    .PULL_DIS(cfg_b.pullup_dis), .PIN(pb_in));
  pcsb_pin_model #(.W(8)) pin_c (.CLK(clk), .OUT(pc_out), .OE(pc_oe), .EXT(ext_c), .EXT_EN(en_c),
    .PULL_DIS(cfg_c.pullup_dis), .PIN(pc_in));

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  task automatic sel_load(input logic [7:0] v);
    @(posedge clk);
    sel_wr    <= 1'b1;
    sel_wdata <= v;
    @(posedge clk);
    sel_wr    <= 1'b0;
    #1;
  endtask : sel_load

  // Configuration write; captures the exchange pulse and data
  task automatic cfg_put(input logic [1:0] p, input logic [7:0] d);
    @(posedge clk);
    cfg_wr       <= 1'b1;
    cfg_req.port <= p;
    cfg_req.data <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
    #1;
    vld = cfg_swap_vld;
    rd  = cfg_swap_data;
  endtask : cfg_put

  // File access; a read captures valid, data and address hit
  task automatic file_op(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    file_wr    <= w;
    file_rd    <= !w;
    file_addr  <= a;
    file_wdata <= d;
    #1;
    hit = file_hit;
    @(posedge clk);
    file_wr <= 1'b0;
    file_rd <= 1'b0;
    #1;
    vld = file_rvld;
    rd  = file_rdata;
  endtask : file_op

  task automatic end_sim();
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_b, sel_wr, cfg_wr, file_wr, file_rd, cmp_result} = 6'h00;
    {sel_wdata, file_wdata, ext_b, en_b, ext_c, en_c} = 48'h0;
    {ext_a, en_a, file_addr} = 13'h0;
    cfg_req = '0;
    ce = 1'b1;
    err_count = 0;
    total_checks = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    // Reset state
    chk8(sel_rdata, 8'h0F);
    chk8(cfg_b.dir & cfg_c.pullup_dis & cfg_a.threshold & cfg_c.schmitt_dis & wake_mask & wake_edge, 8'hFF);
    chk8(pb_oe | pc_oe | wake_pend, 8'h00);
    chk1(cmp_enable | cmp_route, 1'b0);
    // Latch loads while input, drives once output
    file_op(1'b1, 5'h06, 8'hA5);
    chk8(pb_oe, 8'h00);
    cfg_put(PCSB_PORT_B, 8'h0F);
    chk8(pb_oe, 8'hF0);
    chk8(pb_out & pb_oe, 8'hA0);
    cfg_put(PCSB_PORT_A, 8'hFA);
    chk8(cfg_a.dir, 8'h0A);
    chk8({4'h0, pa_oe}, 8'h05);
    // Reads return pin levels
    @(posedge clk);
    {ext_b, en_b, ext_a, en_a} <= {16'h3CFF, 8'hFF};
    file_op(1'b0, 5'h06, 8'h00);
    chk8(rd, 8'hAC);
    chk1(vld & hit, 1'b1);
    file_op(1'b0, 5'h05, 8'h00);
    chk8(rd, 8'h0A);
    file_op(1'b1, 5'h07, 8'h5A);
    cfg_put(PCSB_PORT_C, 8'h00);
    file_op(1'b0, 5'h07, 8'h00);
    chk8(rd, 8'h5A);
    chk8(n_rdata | n_pc_oe, 8'h5A);
    file_op(1'b0, 5'h08, 8'h00);
    chk8({vld, hit, 6'h00} | rd, 8'h00);
    // Selector read-back and persistence
    sel_load(PCSB_SEL_PULL);
    chk8(sel_rdata, 8'h0E);
    cfg_put(PCSB_PORT_A, 8'h03);
    cfg_put(PCSB_PORT_B, 8'hFF);
    cfg_put(PCSB_PORT_C, 8'h00);
    chk8(cfg_a.pullup_dis, 8'h03);
    chk8(cfg_b.pullup_dis, 8'hFF);
    chk8(cfg_c.pullup_dis, 8'h00);
    chk8(cfg_b.dir, 8'h0F);
    // Threshold, Schmitt, wake mask and edge
    sel_load(PCSB_SEL_THR);
    cfg_put(PCSB_PORT_B, 8'h12);
    chk8(cfg_b.threshold, 8'h12);
    sel_load(PCSB_SEL_SCHM);
    cfg_put(PCSB_PORT_C, 8'h34);
    chk8(cfg_c.schmitt_dis, 8'h34);
    cfg_put(PCSB_PORT_A, 8'h00);
    chk8({vld, 7'h00} | cfg_a.schmitt_dis, 8'hFF);
    sel_load(PCSB_SEL_WMASK);
    cfg_put(PCSB_PORT_B, 8'h00);
    chk8(wake_mask, 8'h00);
    sel_load(PCSB_SEL_EDGE);
    cfg_put(PCSB_PORT_B, 8'h00);
    chk8(wake_edge, 8'h00);
    // Pending bits catch rising edges, not falling edges, of enabled pins
    sel_load(PCSB_SEL_DIR);
    cfg_put(PCSB_PORT_B, 8'hFF);
    sel_load(PCSB_SEL_PEND);
    cfg_put(PCSB_PORT_B, 8'h00);
    @(posedge clk);
    ext_b <= 8'h0F;
    repeat (3) @(posedge clk);
    cfg_put(PCSB_PORT_B, 8'h00);
    chk1(vld, 1'b1);
    chk8(rd, 8'h03);
    cfg_put(PCSB_PORT_B, 8'h00);
    chk8(rd, 8'h00);
    // Comparator exchange, enable, routing and live result
    sel_load(PCSB_SEL_CMP);
    cfg_put(PCSB_PORT_B, 8'h3F);
    chk8(rd, 8'hFE);
    chk1(vld & cmp_enable & cmp_route, 1'b1);
    @(posedge clk);
    cmp_result <= 1'b1;
    @(posedge clk);
    #1;
    chk1(pb_oe[0] & pb_out[0], 1'b1);
    cfg_put(PCSB_PORT_B, 8'hC0);
    chk8(rd, 8'h3F);
    chk1(cmp_enable, 1'b0);
    cfg_put(PCSB_PORT_A, 8'h00);
    chk1(vld, 1'b0);
    // Legal selector with no port C entry reaches nothing
    sel_load(PCSB_SEL_WMASK);
    cfg_put(PCSB_PORT_C, 8'hFF);
    chk1(vld, 1'b0);
    chk8(wake_mask | cfg_c.dir, 8'h00);
    // Frozen clock enable ignores a selector load
    @(posedge clk);
    ce <= 1'b0;
    sel_load(PCSB_SEL_DIR);
    chk8(sel_rdata, 8'h0B);
    end_sim();
  end
endmodule : test_port_config_select_bank
`default_nettype wire

// [rtl/pcsb_pkg.sv]
package pcsb_pkg;

  // ----------------------------------------------------------------
  // Selector values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PCSB_SEL_CMP    = 8'h08;
  localparam logic [7:0] PCSB_SEL_PEND   = 8'h09;
  localparam logic [7:0] PCSB_SEL_EDGE   = 8'h0A;
  localparam logic [7:0] PCSB_SEL_WMASK  = 8'h0B;
  localparam logic [7:0] PCSB_SEL_SCHM   = 8'h0C;
  localparam logic [7:0] PCSB_SEL_THR    = 8'h0D;
  localparam logic [7:0] PCSB_SEL_PULL   = 8'h0E;
  localparam logic [7:0] PCSB_SEL_DIR    = 8'h0F;
  localparam logic [7:0] PCSB_SEL_RST    = 8'h0F;
  localparam logic [7:0] PCSB_CFG_RST    = 8'hFF;
  localparam logic [7:0] PCSB_PEND_RST   = 8'h00;
  localparam logic [7:0] PCSB_CMP_RST    = 8'hFF;
  localparam logic [7:0] PCSB_DATA_RST   = 8'h00;
  localparam logic [7:0] PCSB_NARROW_MSK = 8'h0F;

  // ----------------------------------------------------------------
  // Comparator control field positions
  // ----------------------------------------------------------------
  localparam int PCSB_CMP_OFF_BIT   = 7;
  localparam int PCSB_CMP_ROUTE_BIT = 6;
  localparam int PCSB_CMP_RES_BIT   = 0;

  // ----------------------------------------------------------------
  // Port codes and file addresses
  // ----------------------------------------------------------------
  localparam logic [1:0] PCSB_PORT_A = 2'h0;
  localparam logic [1:0] PCSB_PORT_B = 2'h1;
  localparam logic [1:0] PCSB_PORT_C = 2'h2;
  localparam logic [4:0] PCSB_ADDR_A = 5'h05;
  localparam logic [4:0] PCSB_ADDR_B = 5'h06;
  localparam logic [4:0] PCSB_ADDR_C = 5'h07;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] port;
    logic [7:0] data;
  } pcsb_cfgwr_s;

  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] pullup_dis;
    logic [7:0] threshold;
    logic [7:0] schmitt_dis;
  } pcsb_pincfg_s;

endpackage : pcsb_pkg

// [rtl/pcsb_port_config.sv]
`timescale 1ns/10ps
`default_nettype none
// How it works
// (RULE1) The selector value picks which register a configuration write reaches.
// (RULE2) Software loads only selector values 08h through 0Fh.
// (RULE3) Selector has its own load strobe and read-back port, not file-mapped.
// (RULE4) Selector resets to 0Fh, the direction registers.
// (RULE5) Selector value holds until software loads another.
// (RULE6) Selector 0Fh: one makes pin an input, zero an output.
// (RULE7) Selector 0Eh: one disconnects pull-up, zero connects it, all ports.
// (RULE8) Selector 0Dh: one TTL, zero CMOS, used when Schmitt is off.
// (RULE9) Selector 0Ch: Schmitt disable for ports B and C only.
// (RULE10) Selector 0Bh: port B wake mask, zero enables detection.
// (RULE11) Selector 0Ah: port B wake edge, zero rising, one falling.
// (RULE12) Selector 09h: port B write exchanges working value and pending bits.
// (RULE13) Pending bit sets on a selected edge of an enabled pin.
// (RULE14) Selector 08h: exchange with comparator control; bit7 low on, bit6 routes.
// (RULE15) Comparator bit 0 reads the live comparator result.
// (RULE16) Config registers, comparator included, reset to FFh except pending.
// (RULE17) Port data at file addresses 05h, 06h and 07h.
// (RULE18) Without port C, address 07h is a plain storage byte.
// (RULE19) Data reads return pin levels, not latch contents.
// (RULE20) Writes always load the latch; it drives once pin becomes output.
// (RULE21) Port A keeps only its four low bits.
// (RULE22) Writes to unused entries change nothing and give no exchange.
module pcsb_port_config
  import pcsb_pkg::*;
#(
  parameter bit HAS_PORT_C = 1'b1                 // Build variant with third port
) (
  input  wire logic         CLK,                  // Core clock
  input  wire logic         RST_B,                // Async reset, active low
  input  wire logic         CE,                   // Clock enable
  input  wire logic         SEL_WR,               // Load selector strobe
  input  wire logic [7:0]   SEL_WDATA,            // Selector value to load
  output logic      [7:0]   SEL_RDATA,            // Selector read-back
  input  wire logic         CFG_WR,               // Configuration write strobe
  input  wire pcsb_cfgwr_s  CFG_REQ,              // Target port and working value
  output logic              CFG_SWAP_VLD,         // Exchange result valid pulse
  output logic      [7:0]   CFG_SWAP_DATA,        // Old value for working register
  input  wire logic         FILE_WR,              // File write strobe
  input  wire logic         FILE_RD,              // File read strobe
  input  wire logic [4:0]   FILE_ADDR,            // File address
  input  wire logic [7:0]   FILE_WDATA,           // File write data
  output logic              FILE_RVLD,            // Read data valid pulse
  output logic      [7:0]   FILE_RDATA,           // Read data
  output logic              FILE_HIT,             // Address is a port location
  input  wire logic [3:0]   PA_IN,                // Port A pin levels
  output logic      [3:0]   PA_OUT,               // Port A output levels
  output logic      [3:0]   PA_OE,                // Port A drive enables
  input  wire logic [7:0]   PB_IN,                // Port B pin levels
  output logic      [7:0]   PB_OUT,               // Port B output levels
  output logic      [7:0]   PB_OE,                // Port B drive enables
  input  wire logic [7:0]   PC_IN,                // Port C pin levels
  output logic      [7:0]   PC_OUT,               // Port C output levels
  output logic      [7:0]   PC_OE,                // Port C drive enables
  output pcsb_pincfg_s      CFG_A,                // Port A pad settings
  output pcsb_pincfg_s      CFG_B,                // Port B pad settings
  output pcsb_pincfg_s      CFG_C,                // Port C pad settings
  output logic      [7:0]   WAKE_MASK,            // Port B wake mask
  output logic      [7:0]   WAKE_EDGE,            // Port B wake edge select
  output logic      [7:0]   WAKE_PEND,            // Port B pending bits
  input  wire logic         CMP_RESULT,           // Comparator result, plus above minus
  output logic              CMP_ENABLE,           // Comparator powered
  output logic              CMP_ROUTE             // Comparator result on pin 0
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Entry exists for this selector and port
  function automatic logic cfg_hit(input logic [7:0] sel, input logic [1:0] port, input logic c_ok);
    logic r;
    r = 1'b0;
    case (port)
      PCSB_PORT_A: r = (sel >= PCSB_SEL_THR) && (sel <= PCSB_SEL_DIR);
      PCSB_PORT_B: r = (sel >= PCSB_SEL_CMP) && (sel <= PCSB_SEL_DIR);
      PCSB_PORT_C: r = c_ok && (sel >= PCSB_SEL_SCHM) && (sel <= PCSB_SEL_DIR);
      default:     r = 1'b0;
    endcase
    return r;
  endfunction : cfg_hit

  // Trim to the implemented width of a port
  function automatic logic [7:0] port_mask(input logic [1:0] port, input logic [7:0] v);
    return (port == PCSB_PORT_A) ? (v & PCSB_NARROW_MSK) : v;
  endfunction : port_mask

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]   sel_r;
  pcsb_pincfg_s cfg_r [3];
  logic [7:0]   wmask_r;
  logic [7:0]   wedge_r;
  logic [7:0]   pend_r;
  logic [7:0]   pend_nxt;
  logic [7:0]   cmp_r;
  logic [7:0]   latch_r [3];
  logic [7:0]   pb_prev_r;
  logic [7:0]   edge_hit;
  logic         wr_ok;
  logic         cfg_go;
  logic [7:0]   wval;
  logic [7:0]   cmp_view;

  assign wr_ok    = CFG_WR && CE;
  assign cfg_go   = wr_ok && cfg_hit(sel_r, CFG_REQ.port, HAS_PORT_C);  // RULE1 RULE22
  assign wval     = port_mask(CFG_REQ.port, CFG_REQ.data);              // RULE21
  assign cmp_view = {cmp_r[7:1], CMP_RESULT};                           // RULE15

  // ----------------------------------------------------------------
  // Selector
  // ----------------------------------------------------------------
  // Loaded only by its own strobe, holds otherwise
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sel_r <= PCSB_SEL_RST;                      // RULE4
    end else if (CE && SEL_WR) begin
      sel_r <= SEL_WDATA;                         // RULE3 RULE5
    end
  end

  assign SEL_RDATA = sel_r;                       // RULE3

  // ----------------------------------------------------------------
  // Pad configuration registers
  // ----------------------------------------------------------------
  // Direction, pull-up, threshold and Schmitt per port
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < 3; i++) begin
        cfg_r[i] <= {4{PCSB_CFG_RST}};            // RULE16
      end
    end else if (cfg_go) begin
      case (sel_r)
        PCSB_SEL_DIR:  cfg_r[CFG_REQ.port].dir         <= wval;  // RULE6
        PCSB_SEL_PULL: cfg_r[CFG_REQ.port].pullup_dis  <= wval;  // RULE7
        PCSB_SEL_THR:  cfg_r[CFG_REQ.port].threshold   <= wval;  // RULE8
        PCSB_SEL_SCHM: cfg_r[CFG_REQ.port].schmitt_dis <= wval;  // RULE9
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Wake and comparator registers of port B
  // ----------------------------------------------------------------
  // Mask and edge selection
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wmask_r <= PCSB_CFG_RST;                    // RULE16
      wedge_r <= PCSB_CFG_RST;
    end else if (cfg_go && (CFG_REQ.port == PCSB_PORT_B)) begin
      if (sel_r == PCSB_SEL_WMASK) begin
        wmask_r <= wval;                          // RULE10
      end
      if (sel_r == PCSB_SEL_EDGE) begin
        wedge_r <= wval;                          // RULE11
      end
    end
  end

  // Previous pin sample for edge detection
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pb_prev_r <= PCSB_DATA_RST;
    end else if (CE) begin
      pb_prev_r <= PB_IN;
    end
  end

  // Selected edge on an enabled pin
  assign edge_hit = ((wedge_r & pb_prev_r & ~PB_IN) | (~wedge_r & ~pb_prev_r & PB_IN)) & ~wmask_r;  // RULE13 RULE11

  // Pending: new edges win over an exchange in the same cycle
  always_comb begin
    pend_nxt = pend_r | edge_hit;                 // RULE13
    if (cfg_go && (CFG_REQ.port == PCSB_PORT_B) && (sel_r == PCSB_SEL_PEND)) begin
      pend_nxt = wval | edge_hit;                 // RULE12
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pend_r <= PCSB_PEND_RST;
    end else if (CE) begin
      pend_r <= pend_nxt;
    end
  end

  // Comparator control, bit 0 is stored but reads back the live result
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cmp_r <= PCSB_CMP_RST;
    end else if (cfg_go && (CFG_REQ.port == PCSB_PORT_B) && (sel_r == PCSB_SEL_CMP)) begin
      cmp_r <= wval;                              // RULE14
    end
  end

  // ----------------------------------------------------------------
  // Exchange answer
  // ----------------------------------------------------------------
  // Old contents returned one cycle after an exchange write
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      CFG_SWAP_VLD  <= 1'b0;
      CFG_SWAP_DATA <= PCSB_DATA_RST;
    end else if (CE) begin
      CFG_SWAP_VLD <= 1'b0;
      if (cfg_go && (CFG_REQ.port == PCSB_PORT_B) && (sel_r == PCSB_SEL_PEND)) begin
        CFG_SWAP_VLD  <= 1'b1;                    // RULE12
        CFG_SWAP_DATA <= pend_r;
      end else if (cfg_go && (CFG_REQ.port == PCSB_PORT_B) && (sel_r == PCSB_SEL_CMP)) begin
        CFG_SWAP_VLD  <= 1'b1;                    // RULE14
        CFG_SWAP_DATA <= cmp_view;                // RULE15
      end
    end
  end

  // ----------------------------------------------------------------
  // Port data latches and file reads
  // ----------------------------------------------------------------
  // Latches load on every write, whatever the direction
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < 3; i++) begin
        latch_r[i] <= PCSB_DATA_RST;
      end
    end else if (CE && FILE_WR) begin
      case (FILE_ADDR)
        PCSB_ADDR_A: latch_r[0] <= port_mask(PCSB_PORT_A, FILE_WDATA);  // RULE20 RULE21
        PCSB_ADDR_B: latch_r[1] <= FILE_WDATA;                          // RULE17 RULE20
        PCSB_ADDR_C: latch_r[2] <= FILE_WDATA;                          // RULE18
        default: ;
      endcase
    end
  end

  assign FILE_HIT = (FILE_ADDR == PCSB_ADDR_A) || (FILE_ADDR == PCSB_ADDR_B)
                 || (FILE_ADDR == PCSB_ADDR_C);   // RULE17

  // Reads return pin levels; 07h without port C returns stored byte
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      FILE_RVLD  <= 1'b0;
      FILE_RDATA <= PCSB_DATA_RST;
    end else if (CE) begin
      FILE_RVLD <= FILE_RD && FILE_HIT;
      if (FILE_RD) begin
        case (FILE_ADDR)
          PCSB_ADDR_A: FILE_RDATA <= {4'h0, PA_IN};                      // RULE19 RULE21
          PCSB_ADDR_B: FILE_RDATA <= PB_IN;                              // RULE19
          PCSB_ADDR_C: FILE_RDATA <= HAS_PORT_C ? PC_IN : latch_r[2];    // RULE18 RULE19
          default:     FILE_RDATA <= PCSB_DATA_RST;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive and configuration outputs
  // ----------------------------------------------------------------
  // Zero in direction drives the pin from its latch; an enabled and routed comparator drives port B pin 0
  assign PA_OUT = latch_r[0][3:0];
  assign PA_OE  = ~cfg_r[0].dir[3:0];             // RULE6
  assign PB_OUT = (CMP_ENABLE && CMP_ROUTE) ? {latch_r[1][7:1], CMP_RESULT} : latch_r[1];  // RULE14
  assign PB_OE  = (CMP_ENABLE && CMP_ROUTE) ? {~cfg_r[1].dir[7:1], 1'b1} : ~cfg_r[1].dir;
  assign PC_OUT = HAS_PORT_C ? latch_r[2] : PCSB_DATA_RST;
  assign PC_OE  = HAS_PORT_C ? ~cfg_r[2].dir : PCSB_DATA_RST;  // RULE18

  assign CFG_A      = cfg_r[0];
  assign CFG_B      = cfg_r[1];
  assign CFG_C      = cfg_r[2];
  assign WAKE_MASK  = wmask_r;
  assign WAKE_EDGE  = wedge_r;
  assign WAKE_PEND  = pend_r;
  assign CMP_ENABLE = ~cmp_r[PCSB_CMP_OFF_BIT];   // RULE14
  assign CMP_ROUTE  = ~cmp_r[PCSB_CMP_ROUTE_BIT];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  property p_sel_hold;
    !(CE && SEL_WR) |=> $stable(SEL_RDATA);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("selector changed without load");  // RULE5

  property p_dir_write;
    (cfg_go && sel_r == PCSB_SEL_DIR && CFG_REQ.port == PCSB_PORT_B) |=> (CFG_B.dir == $past(wval));
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost");  // RULE6

  property p_pull_write;
    (cfg_go && sel_r == PCSB_SEL_PULL && CFG_REQ.port == PCSB_PORT_C) |=> (CFG_C.pullup_dis == $past(wval));
  endproperty
  a_pull_write: assert property (p_pull_write) else $error("pull-up write lost");  // RULE7

  property p_unused_quiet;
    (wr_ok && !cfg_hit(sel_r, CFG_REQ.port, HAS_PORT_C)) |=> !CFG_SWAP_VLD && $stable(CFG_A) && $stable(CFG_B)
      && $stable(CFG_C) && $stable(WAKE_MASK) && $stable(WAKE_EDGE);
  endproperty
  a_unused_quiet: assert property (p_unused_quiet) else $error("unused entry changed state");  // RULE22

  property p_pend_swap;
    (cfg_go && sel_r == PCSB_SEL_PEND && CFG_REQ.port == PCSB_PORT_B) |=> CFG_SWAP_VLD
      && (CFG_SWAP_DATA == $past(WAKE_PEND)) && ((WAKE_PEND & $past(wval)) == $past(wval));
  endproperty
  a_pend_swap: assert property (p_pend_swap) else $error("pending exchange wrong");  // RULE12

  property p_pend_set;
    (CE && edge_hit != 8'h00) |=> ((WAKE_PEND & $past(edge_hit)) == $past(edge_hit));
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("edge did not set pending");  // RULE13

  property p_cmp_result;
    (cfg_go && sel_r == PCSB_SEL_CMP && CFG_REQ.port == PCSB_PORT_B) |=> CFG_SWAP_VLD
      && (CFG_SWAP_DATA[PCSB_CMP_RES_BIT] == $past(CMP_RESULT));
  endproperty
  a_cmp_result: assert property (p_cmp_result) else $error("comparator result bit wrong");  // RULE15

  property p_cmp_route;
    (CMP_ENABLE && CMP_ROUTE) |-> PB_OE[0] && (PB_OUT[0] == CMP_RESULT);
  endproperty
  a_cmp_route: assert property (p_cmp_route) else $error("comparator not on pin 0");  // RULE14

  property p_read_pins;
    (CE && FILE_RD && FILE_ADDR == PCSB_ADDR_B) |=> FILE_RVLD && (FILE_RDATA == $past(PB_IN));
  endproperty
  a_read_pins: assert property (p_read_pins) else $error("port read not from pins");  // RULE19

  property p_narrow_a;
    (CE && FILE_RD && FILE_ADDR == PCSB_ADDR_A) |=> (FILE_RDATA[7:4] == 4'h0);
  endproperty
  a_narrow_a: assert property (p_narrow_a) else $error("port A upper bits not zero");  // RULE21

  c_pend_swap: cover property (cfg_go && sel_r == PCSB_SEL_PEND ##1 CFG_SWAP_VLD);
  c_cmp_swap:  cover property (cfg_go && sel_r == PCSB_SEL_CMP ##1 CFG_SWAP_VLD);
  c_edge_set:  cover property (CE && edge_hit != 8'h00);
  c_out_drive: cover property (PB_OE != 8'h00 ##1 FILE_RVLD);

endmodule : pcsb_port_config
`default_nettype wire
